// ### core/l2dr_readout.sv
// Direct readout of the second-level cache tag, data and victim RAMs over APB.
// Assumes the cache RAM port runs on mclk and answers each request with one
// cacheAck pulse while cacheReq is held.
//
// Behaviour
// - 512KB tag selector: id 0x10, way [20:18], index [12:10] XOR way.
// - 1MB tag selector: index [16:12] direct, [11:9] XOR way, [8:6] direct.
// - 512KB data selector: id 0x11, same fold as tag, index [9:4].
// - 1MB data selector: index [16:12] XOR 01000, [11:9] XOR way, [8:4].
// - 512KB index: PA[15:8] XOR PA[23:16], bits 7:6 from PA.
// - 1MB index: PA[16:8] XOR PA[25:17], bits 7:6 from PA.
// - 512KB victim selector: id 0x12, index [16:6], no way.
// - 1MB victim selector: bit 16 inverted index bit, [15:6] direct.
// - 512KB tag word 0: ECC [40:34], attr [33:32], PA[39:16] at [31:8].
// - 1MB tag word 0: ECC [39:33], attr [32:31], PA[39:17] at [30:8].
// - Tag word 0: non-secure bit 7, vindex [6:5], shareable 4, L1 valid 3.
// - Tag bits [2:0]: 101 modified, 001 exclusive, x11 shared, xx0 invalid.
// - Tag reads return zero in readout words 1 and 2.
// - Data read: bits 63:0 in word 0, bits 127:64 in word 1.
// - Data word 2: upper ECC [15:8], lower ECC [7:0], rest zero.
// - Victim word 0: five byte fields then 24 replacement bits.
// - Victim reads return zero in readout words 1 and 2.
// - Each read yields three 64-bit readout words, 0 to 2.
//
// Chosen here: the address map and the APB slave port.
`timescale 1ns/100ps
module l2dr_readout
  import l2dr_pkg::*;
#(
  parameter bit SIZE_1MB = 1'b0,
  parameter bit HAS_ECC  = 1'b1
) (
  input  wire logic                  mclk,
  input  wire logic                  nrst,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [L2DR_AW-1:0]    paddr,
  input  wire logic [31:0]           pwdata,
  output logic                       pready,
  output logic      [31:0]           prdata,
  output logic                       pslverr,
  output logic                       cacheReq,
  output l2dr_ram_t                  cacheRam,
  output logic      [2:0]            cacheWay,
  output logic      [L2DR_IDX_W-1:0] cacheIndex,
  input  wire logic                  cacheAck,
  input  wire logic [6:0]            tagEcc,
  input  wire logic [1:0]            tagPageHwAttr,
  input  wire logic [23:0]           tagPa,
  input  wire logic                  tagNonSecure,
  input  wire logic [1:0]            tagVirtIdx,
  input  wire logic                  tagShareable,
  input  wire logic                  tagL1Valid,
  input  wire logic [2:0]            tagState,
  input  wire logic [127:0]          ramData,
  input  wire logic [15:0]           ramDataEcc,
  input  wire logic [63:0]           victimInfo
);

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  l2dr_state_t      state;
  logic [31:0]      selector;
  logic [63:0]      ram_readout_word0;
  logic [63:0]      ram_readout_word1;
  logic [63:0]      ram_readout_word2;
  logic [39:0]      physAddr;
  logic             done;
  logic             badId;
  logic             rsvErr;
  logic [1:0]       cohCode;

  wire logic        apbAccess = psel & penable;
  wire logic        apbSetup  = psel & ~penable;
  wire logic        hitSel    = (paddr == L2DR_A_SEL);
  wire logic        hitStatus = (paddr == L2DR_A_STATUS);
  wire logic        hitW0Lo   = (paddr == L2DR_A_W0_LO);
  wire logic        hitW0Hi   = (paddr == L2DR_A_W0_HI);
  wire logic        hitW1Lo   = (paddr == L2DR_A_W1_LO);
  wire logic        hitW1Hi   = (paddr == L2DR_A_W1_HI);
  wire logic        hitW2Lo   = (paddr == L2DR_A_W2_LO);
  wire logic        hitW2Hi   = (paddr == L2DR_A_W2_HI);
  wire logic        hitPaLo   = (paddr == L2DR_A_PA_LO);
  wire logic        hitPaHi   = (paddr == L2DR_A_PA_HI);
  wire logic        hitHash   = (paddr == L2DR_A_HASH);
  wire logic        hitWords  = hitW0Lo | hitW0Hi | hitW1Lo | hitW1Hi | hitW2Lo | hitW2Hi;
  wire logic        hitRo     = hitStatus | hitWords | hitHash;
  wire logic        mapped    = hitSel | hitPaLo | hitPaHi | hitRo;
  wire logic        busy      = (state == L2DR_ST_WAIT);
  // A new selector while a read is outstanding would tear the readout words
  wire logic        selRefuse = hitSel & busy;
  wire logic        badAccess = ~mapped | (pwrite & hitRo) | (pwrite & selRefuse);
  wire logic        apbWrOk   = apbAccess & pwrite & ~badAccess;
  wire logic        selWrite  = apbWrOk & hitSel;

  assign pready  = 1'b1;
  assign pslverr = apbAccess & badAccess;

  // ----------------------------------------------------------------
  // Selector decode
  // ----------------------------------------------------------------
  l2dr_ram_t              decKind;
  logic [2:0]             decWay;
  logic [L2DR_IDX_W-1:0]  decIndex;
  logic                   decRsvBad;

  l2dr_sel_decode #(
    .SIZE_1MB (SIZE_1MB)
  ) u_decode (
    .sel    (pwdata),
    .kind   (decKind),
    .way    (decWay),
    .index  (decIndex),
    .rsvBad (decRsvBad)
  );

  wire logic        startRead = selWrite & (decKind != L2DR_RAM_NONE);
  wire logic        finish    = busy & cacheAck;
  wire logic        badStart  = selWrite & (decKind == L2DR_RAM_NONE);

  // ----------------------------------------------------------------
  // Physical address to set index hash
  // ----------------------------------------------------------------
  wire logic [16:0] hashS = {physAddr[16], physAddr[15:8] ^ physAddr[23:16],
                             physAddr[7:0]};
  wire logic [16:0] hashL = {physAddr[16:8] ^ physAddr[25:17], physAddr[7:0]};
  wire logic [16:0] paHash = SIZE_1MB ? hashL : hashS;

  // ----------------------------------------------------------------
  // Readout formatting
  // ----------------------------------------------------------------
  wire logic [6:0]  eccTag  = HAS_ECC ? tagEcc : 7'h00;
  wire logic [15:0] eccData = HAS_ECC ? ramDataEcc : 16'h0000;
  wire logic [7:0]  tagLow  = {tagNonSecure, tagVirtIdx, tagShareable, tagL1Valid,
                               tagState};
  wire logic [63:0] tagWordS = {23'h00_0000, eccTag, tagPageHwAttr, tagPa, tagLow};
  wire logic [63:0] tagWordL = {24'h00_0000, eccTag, tagPageHwAttr, tagPa[23:1],
                                tagLow};

  logic [63:0] next_word0;
  logic [63:0] next_word1;
  logic [63:0] next_word2;

  always_comb begin
    next_word0 = 64'h0000_0000_0000_0000;
    next_word1 = 64'h0000_0000_0000_0000;
    next_word2 = 64'h0000_0000_0000_0000;
    unique case (cacheRam)
      L2DR_RAM_TAG: begin
        next_word0 = SIZE_1MB ? tagWordL : tagWordS;
      end
      L2DR_RAM_DATA: begin
        next_word0 = ramData[63:0];
        next_word1 = ramData[127:64];
        next_word2 = {48'h0000_0000_0000, eccData};
      end
      L2DR_RAM_VICTIM: begin
        next_word0 = victimInfo;
      end
      L2DR_RAM_NONE: begin
        next_word0 = 64'h0000_0000_0000_0000;
      end
    endcase
  end

  // State x11 is shared whatever its top bit
  wire logic [1:0] next_coh = ~tagState[0]           ? L2DR_COH_INV :
                              tagState[1]            ? L2DR_COH_SHR :
                              (tagState == L2DR_LS_MOD) ? L2DR_COH_MOD :
                              (tagState == L2DR_LS_EXC) ? L2DR_COH_EXC :
                              L2DR_COH_INV;

  // ----------------------------------------------------------------
  // Read sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state      <= L2DR_ST_IDLE;
      cacheRam   <= L2DR_RAM_NONE;
      cacheWay   <= 3'h0;
      cacheIndex <= 17'h0_0000;
    end else begin
      unique case (state)
        L2DR_ST_IDLE: begin
          if (startRead) begin
            state      <= L2DR_ST_WAIT;
            cacheRam   <= decKind;
            cacheWay   <= decWay;
            cacheIndex <= decIndex;
          end
        end
        L2DR_ST_WAIT: begin
          if (cacheAck) begin
            state <= L2DR_ST_IDLE;
          end
        end
      endcase
    end
  end

  assign cacheReq = busy;

  // Words reload all together so software never sees a mixed read
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ram_readout_word0 <= 64'h0000_0000_0000_0000;
      ram_readout_word1 <= 64'h0000_0000_0000_0000;
      ram_readout_word2 <= 64'h0000_0000_0000_0000;
    end else if (finish) begin
      ram_readout_word0 <= next_word0;
      ram_readout_word1 <= next_word1;
      ram_readout_word2 <= next_word2;
    end else if (badStart) begin
      ram_readout_word0 <= 64'h0000_0000_0000_0000;
      ram_readout_word1 <= 64'h0000_0000_0000_0000;
      ram_readout_word2 <= 64'h0000_0000_0000_0000;
    end
  end

  // Completion flag: the setting term wins over the clearing one
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      done    <= 1'b0;
      badId   <= 1'b0;
      rsvErr  <= 1'b0;
      cohCode <= L2DR_COH_INV;
    end else begin
      if (finish | badStart) begin
        done <= 1'b1;
      end else if (startRead) begin
        done <= 1'b0;
      end
      if (selWrite) begin
        badId  <= badStart;
        rsvErr <= decRsvBad;
      end
      if (finish && cacheRam == L2DR_RAM_TAG) begin
        cohCode <= next_coh;
      end
    end
  end

  // ----------------------------------------------------------------
  // Software registers and read data
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      selector <= 32'h0000_0000;
      physAddr <= 40'h00_0000_0000;
    end else begin
      if (selWrite) begin
        selector <= pwdata;
      end
      if (apbWrOk & hitPaLo) begin
        physAddr[31:0] <= pwdata;
      end
      if (apbWrOk & hitPaHi) begin
        physAddr[39:32] <= pwdata[7:0];
      end
    end
  end

  wire logic [31:0] statusWord = {26'h000_0000, cohCode, rsvErr, badId, done, busy};
  wire logic [31:0] rdMux =
    hitSel    ? selector :
    hitStatus ? statusWord :
    hitW0Lo   ? ram_readout_word0[31:0] :
    hitW0Hi   ? ram_readout_word0[63:32] :
    hitW1Lo   ? ram_readout_word1[31:0] :
    hitW1Hi   ? ram_readout_word1[63:32] :
    hitW2Lo   ? ram_readout_word2[31:0] :
    hitW2Hi   ? ram_readout_word2[63:32] :
    hitPaLo   ? physAddr[31:0] :
    hitPaHi   ? {24'h00_0000, physAddr[39:32]} :
    hitHash   ? {15'h0000, paHash} : 32'h0000_0000;

  // Captured in the setup cycle so read data comes from a flip-flop
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h0000_0000;
    end else if (apbSetup & ~pwrite) begin
      prdata <= rdMux;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_tag_done;
    finish && cacheRam == L2DR_RAM_TAG;
  endsequence

  sequence s_vic_done;
    finish && cacheRam == L2DR_RAM_VICTIM;
  endsequence

  sequence s_data_done;
    finish && cacheRam == L2DR_RAM_DATA;
  endsequence

  a_tag_upper_zero: assert property (@(posedge mclk) disable iff (!nrst)
    s_tag_done |=> ram_readout_word1 == 64'h0 && ram_readout_word2 == 64'h0)
    else $error("tag read left words 1 or 2 nonzero");

  a_victim_upper_zero: assert property (@(posedge mclk) disable iff (!nrst)
    s_vic_done |=> ram_readout_word1 == 64'h0 && ram_readout_word2 == 64'h0)
    else $error("victim read left words 1 or 2 nonzero");

  a_data_word_map: assert property (@(posedge mclk) disable iff (!nrst)
    s_data_done |=> ram_readout_word0 == $past(ramData[63:0])
                 && ram_readout_word1 == $past(ramData[127:64]))
    else $error("data words not mapped from data bits");

  a_data_ecc_word: assert property (@(posedge mclk) disable iff (!nrst)
    s_data_done |=> ram_readout_word2[63:16] == 48'h0
                 && ram_readout_word2[15:0] == (HAS_ECC ? $past(ramDataEcc) : 16'h0))
    else $error("data check word wrong");

  a_tag_layout: assert property (@(posedge mclk) disable iff (!nrst)
    s_tag_done |=> (SIZE_1MB ? ram_readout_word0[63:40] == 24'h0
                             && ram_readout_word0[30:8] == $past(tagPa[23:1])
                             : ram_readout_word0[63:41] == 23'h0
                             && ram_readout_word0[31:8] == $past(tagPa))
                && ram_readout_word0[7:0] == $past(tagLow))
    else $error("tag word 0 layout wrong");

  a_way_captured: assert property (@(posedge mclk) disable iff (!nrst)
    startRead && decKind != L2DR_RAM_VICTIM
      |=> cacheReq && cacheWay == $past(pwdata[L2DR_WAY_HI:L2DR_WAY_LO]))
    else $error("way not taken from selector");

  a_index_fold: assert property (@(posedge mclk) disable iff (!nrst)
    startRead && decKind == L2DR_RAM_TAG
      |=> (SIZE_1MB ? (cacheIndex[11:9] ^ cacheWay) == $past(pwdata[11:9])
                    : (cacheIndex[12:10] ^ cacheWay) == $past(pwdata[12:10])))
    else $error("index fold with way wrong");

  a_data_fold: assert property (@(posedge mclk) disable iff (!nrst)
    startRead && decKind == L2DR_RAM_DATA && SIZE_1MB
      |=> (cacheIndex[16:12] ^ L2DR_DATA_FOLD) == $past(pwdata[16:12]))
    else $error("1MB data index fold wrong");

  a_victim_index: assert property (@(posedge mclk) disable iff (!nrst)
    startRead && decKind == L2DR_RAM_VICTIM
      |=> cacheIndex[15:6] == $past(pwdata[15:6])
       && cacheIndex[16] == (SIZE_1MB ? ~$past(pwdata[16]) : $past(pwdata[16])))
    else $error("victim index wrong");

  a_req_held: assert property (@(posedge mclk) disable iff (!nrst)
    cacheReq && !cacheAck |=> cacheReq && $stable(cacheIndex) && $stable(cacheRam))
    else $error("request dropped before answer");

  a_coh_decode: assert property (@(posedge mclk) disable iff (!nrst)
    (s_tag_done and tagState[1:0] == 2'b11) |=> cohCode == L2DR_COH_SHR)
    else $error("shared state misdecoded");

endmodule : l2dr_readout

// ### core/l2dr_pkg.sv
// Constants, types and register map for the second-level cache RAM readout block.
// Assumes a 32-bit APB slave on an 8-bit byte address and one core clock.
package l2dr_pkg;

  // ----------------------------------------------------------------
  // Selector operand layout
  // ----------------------------------------------------------------
  localparam logic [7:0]  L2DR_ID_TAG     = 8'h10;
  localparam logic [7:0]  L2DR_ID_DATA    = 8'h11;
  localparam logic [7:0]  L2DR_ID_VICTIM  = 8'h12;
  localparam int          L2DR_ID_HI      = 31;
  localparam int          L2DR_ID_LO      = 24;
  localparam int          L2DR_WAY_HI     = 20;
  localparam int          L2DR_WAY_LO     = 18;
  localparam logic [4:0]  L2DR_DATA_FOLD  = 5'h08;
  localparam int          L2DR_IDX_W      = 17;

  // Bits that must be zero for each selector form
  localparam logic [31:0] L2DR_RSV_TAG_S  = 32'h00E3_003F;
  localparam logic [31:0] L2DR_RSV_TAG_L  = 32'h00E2_003F;
  localparam logic [31:0] L2DR_RSV_DAT_S  = 32'h00E3_000F;
  localparam logic [31:0] L2DR_RSV_DAT_L  = 32'h00E2_000F;
  localparam logic [31:0] L2DR_RSV_VIC    = 32'h00FE_003F;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int          L2DR_AW         = 8;
  localparam logic [7:0]  L2DR_A_SEL      = 8'h00;
  localparam logic [7:0]  L2DR_A_STATUS   = 8'h04;
  localparam logic [7:0]  L2DR_A_W0_LO    = 8'h08;
  localparam logic [7:0]  L2DR_A_W0_HI    = 8'h0C;
  localparam logic [7:0]  L2DR_A_W1_LO    = 8'h10;
  localparam logic [7:0]  L2DR_A_W1_HI    = 8'h14;
  localparam logic [7:0]  L2DR_A_W2_LO    = 8'h18;
  localparam logic [7:0]  L2DR_A_W2_HI    = 8'h1C;
  localparam logic [7:0]  L2DR_A_PA_LO    = 8'h20;
  localparam logic [7:0]  L2DR_A_PA_HI    = 8'h24;
  localparam logic [7:0]  L2DR_A_HASH     = 8'h28;

  // Status bit positions
  localparam int          L2DR_ST_BUSY    = 0;
  localparam int          L2DR_ST_DONE    = 1;
  localparam int          L2DR_ST_BADID   = 2;
  localparam int          L2DR_ST_RSV     = 3;
  localparam int          L2DR_ST_COH_LO  = 4;

  // Coherence summary of the last tag read
  localparam logic [1:0]  L2DR_COH_INV    = 2'h0;
  localparam logic [1:0]  L2DR_COH_SHR    = 2'h1;
  localparam logic [1:0]  L2DR_COH_EXC    = 2'h2;
  localparam logic [1:0]  L2DR_COH_MOD    = 2'h3;
  localparam logic [2:0]  L2DR_LS_MOD     = 3'h5;
  localparam logic [2:0]  L2DR_LS_EXC     = 3'h1;

  typedef enum logic [3:0] {
    L2DR_RAM_NONE   = 4'b0001,
    L2DR_RAM_TAG    = 4'b0010,
    L2DR_RAM_DATA   = 4'b0100,
    L2DR_RAM_VICTIM = 4'b1000
  } l2dr_ram_t;

  typedef enum logic [1:0] {
    L2DR_ST_IDLE = 2'b01,
    L2DR_ST_WAIT = 2'b10
  } l2dr_state_t;

endpackage : l2dr_pkg

// ### core/l2dr_sel_decode.sv
// Selector operand decoder: RAM kind, way and unfolded set index.
// Assumes a stable operand; purely combinational.
`timescale 1ns/100ps
module l2dr_sel_decode
  import l2dr_pkg::*;
#(
  parameter bit SIZE_1MB = 1'b0
) (
  input  wire logic [31:0]           sel,
  output l2dr_ram_t                  kind,
  output logic      [2:0]            way,
  output logic      [L2DR_IDX_W-1:0] index,
  output logic                       rsvBad
);

  wire logic [7:0]  ramSelectId = sel[L2DR_ID_HI:L2DR_ID_LO];
  wire logic        isTag       = (ramSelectId == L2DR_ID_TAG);
  wire logic        isData      = (ramSelectId == L2DR_ID_DATA);
  wire logic        isVictim    = (ramSelectId == L2DR_ID_VICTIM);
  wire logic [2:0]  selWay      = sel[L2DR_WAY_HI:L2DR_WAY_LO];

  // ----------------------------------------------------------------
  // Index unfolding per size
  // ----------------------------------------------------------------
  wire logic [16:0] idxTagS = {1'b0, sel[15:13], sel[12:10] ^ selWay, sel[9:6], 6'h00};
  wire logic [16:0] idxDatS = {1'b0, sel[15:13], sel[12:10] ^ selWay, sel[9:4], 4'h0};
  wire logic [16:0] idxTagL = {sel[16:12], sel[11:9] ^ selWay, sel[8:6], 6'h00};
  wire logic [16:0] idxDatL = {sel[16:12] ^ L2DR_DATA_FOLD, sel[11:9] ^ selWay,
                               sel[8:4], 4'h0};
  wire logic [16:0] idxVicS = {sel[16:6], 6'h00};
  wire logic [16:0] idxVicL = {~sel[16], sel[15:6], 6'h00};

  wire logic [31:0] rsvMask = isTag  ? (SIZE_1MB ? L2DR_RSV_TAG_L : L2DR_RSV_TAG_S) :
                              isData ? (SIZE_1MB ? L2DR_RSV_DAT_L : L2DR_RSV_DAT_S) :
                              L2DR_RSV_VIC;

  // Size picked at build time
  assign kind   = isTag    ? L2DR_RAM_TAG :
                  isData   ? L2DR_RAM_DATA :
                  isVictim ? L2DR_RAM_VICTIM : L2DR_RAM_NONE;
  assign way    = isVictim ? 3'h0 : selWay;
  assign index  = isTag    ? (SIZE_1MB ? idxTagL : idxTagS) :
                  isData   ? (SIZE_1MB ? idxDatL : idxDatS) :
                  isVictim ? (SIZE_1MB ? idxVicL : idxVicS) : 17'h0_0000;
  // Only reported, the read still proceeds
  assign rsvBad = |(sel & rsvMask);

endmodule : l2dr_sel_decode

// ### tb/l2_cache_ram_direct_read_tb.sv
// Self-checking bench for the cache RAM readout block, both size builds in lockstep.
// Assumes zero-wait APB and a cache side played by the bench itself.
`timescale 1ns/100ps
module l2_cache_ram_direct_read_tb;
  import l2dr_pkg::*;
  logic            mclk, nrst, psel, penable, pwrite, pready, pslverr;
  logic            cacheReq, cacheAck, reqSeen, tagNonSecure, tagShareable, tagL1Valid;
  logic [7:0]      paddr;
  logic [31:0]     pwdata, prdata, rng;
  l2dr_ram_t       cacheRam;
  logic [2:0]      cacheWay, tagState, way;
  logic [16:0]     cacheIndex, idx;
  logic [6:0]      tagEcc;
  logic [1:0]      tagPageHwAttr, tagVirtIdx, coh;
  logic [23:0]     tagPa;
  logic [127:0]    ramData, rnd;
  logic [15:0]     ramDataEcc;
  logic [63:0]     victimInfo;
  logic [39:0]     pa;
  logic [32:0]     eNow, eNowL;
  logic [32:0]     apbQ[$], apbQL[$];
  logic [23:0]     reqQ[$], reqQL[$];
  logic            pslverrL, cacheReqL;
  logic [31:0]     prdataL, sv;
  l2dr_ram_t       cacheRamL;
  logic [2:0]      cacheWayL;
  logic [16:0]     cacheIndexL;
  int              errTotal, checkCount;

  l2dr_readout #(.SIZE_1MB(1'b0), .HAS_ECC(1'b1)) l2dr_readout_i (
    .mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .cacheReq(cacheReq), .cacheRam(cacheRam), .cacheWay(cacheWay),
    .cacheIndex(cacheIndex), .cacheAck(cacheAck), .tagEcc(tagEcc),
    .tagPageHwAttr(tagPageHwAttr), .tagPa(tagPa), .tagNonSecure(tagNonSecure),
    .tagVirtIdx(tagVirtIdx), .tagShareable(tagShareable), .tagL1Valid(tagL1Valid),
    .tagState(tagState), .ramData(ramData), .ramDataEcc(ramDataEcc),
    .victimInfo(victimInfo));

  // Same stimulus, 1MB build
  l2dr_readout #(.SIZE_1MB(1'b1), .HAS_ECC(1'b1)) l2dr_readout_1mb_i (
    .mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(), .prdata(prdataL), .pslverr(pslverrL),
    .cacheReq(cacheReqL), .cacheRam(cacheRamL), .cacheWay(cacheWayL),
    .cacheIndex(cacheIndexL), .cacheAck(cacheAck), .tagEcc(tagEcc),
    .tagPageHwAttr(tagPageHwAttr), .tagPa(tagPa), .tagNonSecure(tagNonSecure),
    .tagVirtIdx(tagVirtIdx), .tagShareable(tagShareable), .tagL1Valid(tagL1Valid),
    .tagState(tagState), .ramData(ramData), .ramDataEcc(ramDataEcc),
    .victimInfo(victimInfo));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : xs

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checkCount++;
    if (got !== exp) begin
      errTotal++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e, input logic [32:0] eL);
    apbQ.push_back(e);
    apbQL.push_back(eL);
    @(posedge mclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic err);
    apb(1'b1, a, d, {err, 32'h0}, {err, 32'h0});
  endtask : wr

  task automatic rd64(input logic [7:0] a, input logic [63:0] e);
    rd2(a, e, e);
  endtask : rd64

  task automatic rd2(input logic [7:0] a, input logic [63:0] e, input logic [63:0] eL);
    apb(1'b0, a, 32'h0, {1'b0, e[31:0]}, {1'b0, eL[31:0]});
    apb(1'b0, a + 8'h04, 32'h0, {1'b0, e[63:32]}, {1'b0, eL[63:32]});
  endtask : rd2

  // Cache side: random answer, random latency, one ack pulse
  task automatic serve();
    rnd = {xs(), xs(), xs(), xs()};
    ramData <= rnd;
    ramDataEcc <= rnd[15:0];
    victimInfo <= rnd[95:32];
    {tagEcc, tagPageHwAttr, tagPa, tagNonSecure, tagVirtIdx, tagShareable,
     tagL1Valid} <= rnd[37:0];
    while (cacheReq !== 1'b1) begin
      @(negedge mclk);
    end
    repeat (xs() % 3) @(negedge mclk);
    @(posedge mclk);
    cacheAck <= 1'b1;
    @(posedge mclk);
    cacheAck <= 1'b0;
    @(posedge mclk);
  endtask : serve

  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", checkCount, errTotal);
    if (errTotal == 0 && checkCount > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : giveVerdict

  // ----------------------------------------------------------------
  // Monitor: oldest expectation against each finished result
  // ----------------------------------------------------------------
  always @(negedge mclk) begin
    if (psel && penable && pready && apbQ.size() > 0) begin
      eNow = apbQ.pop_front();
      eNowL = apbQL.pop_front();
      if (eNow[32] || pwrite) begin
        chk(64'(pslverr), 64'(eNow[32]));
        chk(64'(pslverrL), 64'(eNowL[32]));
      end else begin
        chk(64'({pslverr, prdata}), 64'(eNow));
        chk(64'({pslverrL, prdataL}), 64'(eNowL));
      end
    end
    if (cacheReq === 1'b1 && !reqSeen) begin
      chk(64'(cacheReqL), 64'h1);
      if (reqQ.size() == 0 || reqQL.size() == 0) chk(64'h1, 64'h0);
      else begin
        chk(64'({cacheRam, cacheWay, cacheIndex}), 64'(reqQ.pop_front()));
        chk(64'({cacheRamL, cacheWayL, cacheIndexL}), 64'(reqQL.pop_front()));
      end
    end
    reqSeen = cacheReq;
  end

  initial begin
    repeat (20000) @(posedge mclk);
    errTotal++;
    giveVerdict();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    rng = 32'h2c96_b04f; nrst = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; cacheAck = 1'b0; reqSeen = 1'b0; tagState = 3'h0;
    ramData = '0; ramDataEcc = '0; victimInfo = '0; errTotal = 0; checkCount = 0;
    {tagEcc, tagPageHwAttr, tagPa, tagNonSecure, tagVirtIdx, tagShareable, tagL1Valid} = '0;
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    for (int s = 0; s < 8; s++) begin
      way = 3'(xs());
      idx = 17'(xs()) & 17'h0_FFC0;
      tagState <= 3'(s);
      sv = {L2DR_ID_TAG, 3'h0, way, 2'h0, idx[15:13], idx[12:10] ^ way, idx[9:6], 6'h0};
      reqQ.push_back({L2DR_RAM_TAG, way, idx});
      reqQL.push_back({L2DR_RAM_TAG, way, sv[16:12], sv[11:9] ^ way, sv[8:6], 6'h00});
      wr(L2DR_A_SEL, sv, 1'b0);
      serve();
      coh = !tagState[0] ? 2'h0 : tagState[1] ? 2'h1 : tagState[2] ? 2'h3 : 2'h2;
      apb(1'b0, L2DR_A_STATUS, 32'h0, {1'b0, 26'h0, coh, 4'h2},
          {1'b0, 26'h0, coh, 4'h2});
      rd2(L2DR_A_W0_LO, {23'h0, tagEcc, tagPageHwAttr, tagPa, tagNonSecure, tagVirtIdx,
          tagShareable, tagL1Valid, tagState}, {24'h0, tagEcc, tagPageHwAttr, tagPa[23:1],
          tagNonSecure, tagVirtIdx, tagShareable, tagL1Valid, tagState});
      rd64(L2DR_A_W1_LO, 64'h0);
      rd64(L2DR_A_W2_LO, 64'h0);
    end
    $display("tag reads done");
    for (int k = 0; k < 3; k++) begin
      way = 3'(xs());
      idx = 17'(xs()) & 17'h0_FFF0;
      sv = {L2DR_ID_DATA, 3'h0, way, 2'h0, idx[15:13], idx[12:10] ^ way, idx[9:4], 4'h0};
      reqQ.push_back({L2DR_RAM_DATA, way, idx});
      reqQL.push_back({L2DR_RAM_DATA, way, sv[16:12] ^ 5'h08, sv[11:9] ^ way, sv[8:4],
                       4'h0});
      wr(L2DR_A_SEL, sv, 1'b0);
      wr(L2DR_A_SEL, 32'h0, 1'b1);
      serve();
      rd64(L2DR_A_W0_LO, ramData[63:0]);
      rd64(L2DR_A_W1_LO, ramData[127:64]);
      rd64(L2DR_A_W2_LO, {48'h0, ramDataEcc});
      idx = 17'(xs()) & 17'h1_FFC0;
      sv = {L2DR_ID_VICTIM, 7'h00, idx[16:6], 6'h00};
      reqQ.push_back({L2DR_RAM_VICTIM, 3'h0, idx});
      reqQL.push_back({L2DR_RAM_VICTIM, 3'h0, ~sv[16], sv[15:6], 6'h00});
      wr(L2DR_A_SEL, sv, 1'b0);
      serve();
      rd64(L2DR_A_W0_LO, victimInfo);
      rd64(L2DR_A_W1_LO, 64'h0);
      rd64(L2DR_A_W2_LO, 64'h0);
    end
    $display("data and victim reads done");
    for (int k = 0; k < 4; k++) begin
      pa = {8'(xs()), xs()};
      wr(L2DR_A_PA_LO, pa[31:0], 1'b0);
      wr(L2DR_A_PA_HI, {24'h0, pa[39:32]}, 1'b0);
      apb(1'b0, L2DR_A_HASH, 32'h0,
          {1'b0, 15'h0, pa[16], pa[15:8] ^ pa[23:16], pa[7:0]},
          {1'b0, 15'h0, pa[16:8] ^ pa[25:17], pa[7:0]});
    end
    $display("index hash done");
    wr(L2DR_A_SEL, 32'h0A00_0001, 1'b0);
    rd64(L2DR_A_W0_LO, 64'h0);
    apb(1'b0, L2DR_A_STATUS, 32'h0, {1'b0, 32'h0000_001E}, {1'b0, 32'h0000_001E});
    wr(L2DR_A_STATUS, 32'h0, 1'b1);
    apb(1'b0, 8'h40, 32'h0, {1'b1, 32'h0}, {1'b1, 32'h0});
    repeat (3) @(posedge mclk);
    chk(64'(reqQ.size() + reqQL.size()), 64'h0);
    $display("refusals done");
    giveVerdict();
  end
endmodule : l2_cache_ram_direct_read_tb
